// >>> rtl/adc_link_defines.svh
// Constants for the delta-sigma converter serial link and its host controller
`ifndef ADC_LINK_DEFINES_SVH
`define ADC_LINK_DEFINES_SVH
// Functional notes
// - Single command converts once, then sets done.
// - Flag mode off: host polls done, reads data.
// - Data, gain, offset reads clear done.
// - New single command restarts the conversion.
// - Flag mode: serial out falls on result.
// - Eight null clocks clear flag, MSB follows.
// - Twenty-four more clocks shift result, MSB first.
// - Flag mode: host uses only null command.
// - Flagged single: data mode until word read.
// - Continuous command converts repeatedly, flags each.
// - Unread flag rises one tick before next.
// - Other valid command exits continuous mode.
// - Host finishes read before next result.
// - Conversion command in continuous mode restarts.
// - Continuous mode needs flag mode on.
// - Result is 24 bits: 16 data, flags byte.
// - Tail byte 1111 00, oscillation, overrange.
// - Overrange set outside range, else cleared.
// - Oscillation flag follows modulator detector.
// - Unipolar straight binary, bipolar two's complement.
// - Port acts only with chip select low.

// ----------------------------------------
// Command bytes
// ----------------------------------------
`define CMD_NULL 8'h00
`define CMD_SINGLE 8'hC0
`define CMD_CONT 8'hA0
`define CMD_RD_DATA 8'h96
`define CMD_WR_CFG 8'h81
`define CMD_RD_CFG 8'h91
`define CMD_RD_OFFSET 8'h92
`define CMD_RD_GAIN 8'h93

// ----------------------------------------
// Configuration word
// ----------------------------------------
`define CFG_RESET 24'h000000
`define CFG_RW_MASK 24'hFDF0F7
`define CFG_UNI_BIT 12
`define CFG_PF_BIT 5
`define CFG_DONE_BIT 3
`define CAL_READ_VALUE 24'h000000

// ----------------------------------------
// Result word
// ----------------------------------------
`define TAIL_ONES 4'hF
`define TAIL_ZEROS 2'h0
`define UNI_HI 18'sh0FFFF
`define UNI_LO 18'sh00000
`define BIP_HI 18'sh07FFF
`define BIP_LO 18'sh38000

// ----------------------------------------
// Frame lengths
// ----------------------------------------
`define CMD_LAST 5'h07
`define WORD_LAST 5'h17
`define HOST_SHORT_LAST 6'h07
`define HOST_LONG_LAST 6'h1F

// ----------------------------------------
// Timing
// ----------------------------------------
`define CORE_HZ 32'h05F5E100
`define XIN_HZ 32'h00008000
`define XIN_DIV_DEF ((`CORE_HZ + `XIN_HZ / 2) / `XIN_HZ)
`define CONV_TICKS_DEF 32'h00000888
`define CORE_PERIOD_NS 32'h0000000A
`define SCLK_PERIOD_NS 32'h000000A0
`define SCLK_HALF_DEF ((`SCLK_PERIOD_NS / 2 + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)

// ----------------------------------------
// Host register map (APB byte offsets)
// ----------------------------------------
`define HOST_CMD_OFS 12'h000
`define HOST_TX_OFS 12'h004
`define HOST_RX_OFS 12'h008
`define HOST_STAT_OFS 12'h00C
`define HC_LONG_BIT 8
`define HC_WAITF_BIT 9
`endif

// >>> rtl/adc_link_host.sv
// Host end: APB-programmed serial sequencer for the converter link
`timescale 1ns/1ps
`include "adc_link_defines.svh"
module adc_link_host #(
    parameter int SCLK_HALF = `SCLK_HALF_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    adc_link_if.host link
);
    import adc_link_pkg::*;

    localparam int HW = $clog2(SCLK_HALF + 1);

    host_state_t state_r;
    logic [1:0] sdoSync_r;
    logic csN_r;
    logic sclk_r;
    logic sdi_r;
    logic [HW-1:0] halfCnt_r;
    logic halfEnd;
    logic [5:0] bitCnt_r;
    logic [5:0] lastBit_r;
    logic [31:0] txSh_r;
    logic [9:0] cmdReg_r;
    logic [23:0] txData_r;
    logic [23:0] rxData_r;
    logic [31:0] rdMux;
    logic addrHit;
    logic wrEn;
    logic startOp;

    // ----------------------------------------
    // APB registers
    // ----------------------------------------
    assign addrHit = paddr == `HOST_CMD_OFS || paddr == `HOST_TX_OFS
                     || paddr == `HOST_RX_OFS || paddr == `HOST_STAT_OFS;
    assign wrEn = psel && penable && pwrite && addrHit;
    // Command writes while busy are dropped
    assign startOp = wrEn && paddr == `HOST_CMD_OFS && state_r == HS_IDLE;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrHit;

    always_comb begin
        unique case (paddr)
            `HOST_CMD_OFS: rdMux = {22'h000000, cmdReg_r};
            `HOST_TX_OFS: rdMux = {8'h00, txData_r};
            `HOST_RX_OFS: rdMux = {8'h00, rxData_r};
            `HOST_STAT_OFS: rdMux = {30'h00000000, sdoSync_r[1], state_r != HS_IDLE};
            default: rdMux = 32'h00000000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata <= rdMux;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmdReg_r <= 10'h000;
            txData_r <= 24'h000000;
        end else begin
            if (startOp) begin
                cmdReg_r <= pwdata[9:0];
            end
            if (wrEn && paddr == `HOST_TX_OFS) begin
                txData_r <= pwdata[23:0];
            end
        end
    end

    // ----------------------------------------
    // Serial sequencer
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sdoSync_r <= 2'h3;
        end else begin
            sdoSync_r <= {sdoSync_r[0], link.serialLine};
        end
    end

    assign halfEnd = halfCnt_r == HW'(SCLK_HALF - 1);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= HS_IDLE;
            csN_r <= 1'b1;
            sclk_r <= 1'b0;
            sdi_r <= 1'b0;
            halfCnt_r <= '0;
            bitCnt_r <= 6'h00;
            lastBit_r <= 6'h00;
            txSh_r <= 32'h00000000;
        end else begin
            unique case (state_r)
                HS_IDLE: begin
                    if (startOp) begin
                        txSh_r <= {pwdata[7:0], txData_r};
                        lastBit_r <= pwdata[`HC_LONG_BIT] ? `HOST_LONG_LAST : `HOST_SHORT_LAST;
                        csN_r <= 1'b0;
                        sdi_r <= pwdata[`HC_WAITF_BIT] ? 1'b0 : pwdata[7];
                        halfCnt_r <= '0;
                        bitCnt_r <= 6'h00;
                        state_r <= pwdata[`HC_WAITF_BIT] ? HS_WAITF : HS_RUN;
                    end
                end
                HS_WAITF: begin
                    if (!sdoSync_r[1]) begin
                        sdi_r <= txSh_r[31];
                        halfCnt_r <= '0;
                        state_r <= HS_RUN;
                    end
                end
                HS_RUN: begin
                    if (!halfEnd) begin
                        halfCnt_r <= halfCnt_r + HW'(1);
                    end else begin
                        halfCnt_r <= '0;
                        sclk_r <= !sclk_r;
                        if (sclk_r) begin
                            if (bitCnt_r == lastBit_r) begin
                                csN_r <= 1'b1;
                                state_r <= HS_IDLE;
                            end else begin
                                bitCnt_r <= bitCnt_r + 6'h01;
                                txSh_r <= {txSh_r[30:0], 1'b0};
                                sdi_r <= txSh_r[30];
                            end
                        end
                    end
                end
                default: begin
                    state_r <= HS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rxData_r <= 24'h000000;
        end else if (state_r == HS_RUN && halfEnd && !sclk_r) begin
            rxData_r <= {rxData_r[22:0], sdoSync_r[1]};
        end
    end

    assign link.csN = csN_r;
    assign link.sclk = sclk_r;
    assign link.serialIn = sdi_r;
endmodule

// >>> rtl/adc_link_if.sv
// Four-wire serial link between converter and host
`timescale 1ns/1ps
interface adc_link_if;
    logic csN;
    logic sclk;
    logic serialIn;
    logic serialOut;
    logic serialOutEn;
    logic serialLine;

    // Released line reads high
    assign serialLine = serialOutEn ? serialOut : 1'b1;

    modport device(input csN, input sclk, input serialIn, output serialOut, output serialOutEn);
    modport host(output csN, output sclk, output serialIn, input serialLine);
endinterface

// >>> rtl/adc_link_pkg.sv
// Types shared by both ends of the converter serial link
package adc_link_pkg;
    typedef logic signed [17:0] sample_t;
    typedef enum logic [1:0] {ST_CMD, ST_WAIT, ST_READ, ST_WRITE} dev_state_t;
    typedef enum logic [1:0] {HS_IDLE, HS_WAITF, HS_RUN} host_state_t;
endpackage

// >>> rtl/adc_serial_dev.sv
// Converter end: command decode, conversion sequencing and result readout
`timescale 1ns/1ps
`include "adc_link_defines.svh"
module adc_serial_dev #(
    parameter int XIN_DIV = `XIN_DIV_DEF,
    parameter int CONV_TICKS = `CONV_TICKS_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Serial link
    adc_link_if.device link,
    // Modulator and filter result
    input wire adc_link_pkg::sample_t sampleIn,
    input wire logic oscDetect,
    // Status
    output logic convBusy,
    output logic contMode
);
    import adc_link_pkg::*;

    localparam int XW = $clog2(XIN_DIV + 1);
    localparam int TW = $clog2(CONV_TICKS + 1);

    logic [1:0] csSync_r;
    logic [1:0] sclkSync_r;
    logic [1:0] sdiSync_r;
    logic sclkDly_r;
    logic sclkRise;
    logic sclkFall;
    dev_state_t state_r;
    dev_state_t state_nxt;
    logic [4:0] bitCnt_r;
    logic [23:0] inSh_r;
    logic [23:0] outSh_r;
    logic [23:0] outSh_nxt;
    logic [23:0] cfgRw_r;
    logic [23:0] cfgImage;
    logic [23:0] resultWord_r;
    logic outBit_r;
    logic flagLow_r;
    logic done_r;
    logic convBusy_r;
    logic contMode_r;
    logic [XW-1:0] xinCnt_r;
    logic xinTick;
    logic [TW-1:0] tickCnt_r;
    logic byteDone;
    logic wordDone;
    logic convDone;
    logic preRise;
    logic [7:0] cmdByte;
    logic [23:0] rxWord;
    logic execCmd;
    logic startConv;
    logic stopConv;
    logic setCont;
    logic loadOut;
    logic clrDone;
    logic takeFlag;
    logic pfOn;
    logic uniOn;
    sample_t hiLim;
    sample_t loLim;
    logic [15:0] code;
    logic ovr;

    // ----------------------------------------
    // Pin synchronisers and edge detect
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            csSync_r <= 2'h3;
            sclkSync_r <= 2'h0;
            sdiSync_r <= 2'h0;
            sclkDly_r <= 1'b0;
        end else begin
            csSync_r <= {csSync_r[0], link.csN};
            sclkSync_r <= {sclkSync_r[0], link.sclk};
            sdiSync_r <= {sdiSync_r[0], link.serialIn};
            sclkDly_r <= sclkSync_r[1];
        end
    end

    assign sclkRise = !csSync_r[1] && sclkSync_r[1] && !sclkDly_r;
    assign sclkFall = !csSync_r[1] && !sclkSync_r[1] && sclkDly_r;

    // ----------------------------------------
    // Bit framing
    // ----------------------------------------
    assign byteDone = sclkRise && bitCnt_r == `CMD_LAST
                      && (state_r == ST_CMD || state_r == ST_WAIT);
    assign wordDone = sclkRise && bitCnt_r == `WORD_LAST
                      && (state_r == ST_READ || state_r == ST_WRITE);
    assign cmdByte = {inSh_r[6:0], sdiSync_r[1]};
    assign rxWord = {inSh_r[22:0], sdiSync_r[1]};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bitCnt_r <= 5'h00;
        end else if (byteDone || wordDone) begin
            bitCnt_r <= 5'h00;
        end else if (sclkRise) begin
            bitCnt_r <= bitCnt_r + 5'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            inSh_r <= 24'h000000;
        end else if (sclkRise) begin
            inSh_r <= rxWord;
        end
    end

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        execCmd = 1'b0;
        startConv = 1'b0;
        stopConv = 1'b0;
        setCont = 1'b0;
        loadOut = 1'b0;
        outSh_nxt = resultWord_r;
        clrDone = 1'b0;
        takeFlag = 1'b0;
        if (byteDone) begin
            if (state_r == ST_CMD) begin
                execCmd = 1'b1;
            end else if (cmdByte == `CMD_NULL) begin
                if (flagLow_r) begin
                    takeFlag = 1'b1;
                    loadOut = 1'b1;
                    clrDone = 1'b1;
                    state_nxt = ST_READ;
                end
            end else if (contMode_r) begin
                if (cmdByte == `CMD_SINGLE || cmdByte == `CMD_CONT) begin
                    startConv = 1'b1;
                end else begin
                    stopConv = 1'b1;
                    execCmd = 1'b1;
                end
            end
        end
        if (execCmd) begin
            unique case (cmdByte)
                `CMD_SINGLE: begin
                    startConv = 1'b1;
                    state_nxt = pfOn ? ST_WAIT : ST_CMD;
                end
                `CMD_CONT: begin
                    startConv = pfOn;
                    setCont = pfOn;
                    state_nxt = pfOn ? ST_WAIT : ST_CMD;
                end
                `CMD_RD_DATA: begin
                    loadOut = 1'b1;
                    clrDone = 1'b1;
                    state_nxt = ST_READ;
                end
                `CMD_RD_CFG: begin
                    loadOut = 1'b1;
                    outSh_nxt = cfgImage;
                    state_nxt = ST_READ;
                end
                `CMD_RD_OFFSET, `CMD_RD_GAIN: begin
                    loadOut = 1'b1;
                    outSh_nxt = `CAL_READ_VALUE;
                    clrDone = 1'b1;
                    state_nxt = ST_READ;
                end
                `CMD_WR_CFG: begin
                    state_nxt = ST_WRITE;
                end
                default: begin
                    state_nxt = ST_CMD;
                end
            endcase
        end
        if (wordDone) begin
            state_nxt = (state_r == ST_READ && contMode_r) ? ST_WAIT : ST_CMD;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= ST_CMD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------
    // Configuration word
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfgRw_r <= `CFG_RESET;
        end else if (wordDone && state_r == ST_WRITE) begin
            cfgRw_r <= rxWord & `CFG_RW_MASK;
        end
    end

    assign pfOn = cfgRw_r[`CFG_PF_BIT];
    assign uniOn = cfgRw_r[`CFG_UNI_BIT];

    always_comb begin
        cfgImage = cfgRw_r;
        cfgImage[`CFG_DONE_BIT] = done_r;
    end

    // ----------------------------------------
    // Master clock tick and conversion timer
    // ----------------------------------------
    assign xinTick = xinCnt_r == XW'(XIN_DIV - 1);
    assign convDone = xinTick && convBusy_r && tickCnt_r == TW'(CONV_TICKS - 1);
    // Unread result: release flag one tick ahead of the next
    assign preRise = xinTick && convBusy_r && contMode_r && flagLow_r
                     && tickCnt_r == TW'(CONV_TICKS - 2)
                     && state_r == ST_WAIT && bitCnt_r == 5'h00;

    always_ff @(posedge core_clk) begin
        if (rst || xinTick) begin
            xinCnt_r <= '0;
        end else begin
            xinCnt_r <= xinCnt_r + XW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            convBusy_r <= 1'b0;
            tickCnt_r <= '0;
        end else if (startConv) begin
            convBusy_r <= 1'b1;
            tickCnt_r <= '0;
        end else if (stopConv) begin
            convBusy_r <= 1'b0;
        end else if (convDone) begin
            convBusy_r <= contMode_r;
            tickCnt_r <= '0;
        end else if (xinTick && convBusy_r) begin
            tickCnt_r <= tickCnt_r + TW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || stopConv) begin
            contMode_r <= 1'b0;
        end else if (setCont) begin
            contMode_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // Result coding
    // ----------------------------------------
    always_comb begin
        hiLim = uniOn ? `UNI_HI : `BIP_HI;
        loLim = uniOn ? `UNI_LO : `BIP_LO;
        ovr = 1'b1;
        if (sampleIn > hiLim) begin
            code = hiLim[15:0];
        end else if (sampleIn < loLim) begin
            code = loLim[15:0];
        end else begin
            code = sampleIn[15:0];
            ovr = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            resultWord_r <= 24'h000000;
        end else if (convDone) begin
            resultWord_r <= {code, `TAIL_ONES, `TAIL_ZEROS, oscDetect, ovr};
        end
    end

    // ----------------------------------------
    // Done indicator and ready flag
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            done_r <= 1'b0;
        end else if (convDone) begin
            done_r <= 1'b1;
        end else if (clrDone) begin
            done_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flagLow_r <= 1'b0;
        end else if (convDone && pfOn) begin
            flagLow_r <= 1'b1;
        end else if (takeFlag || preRise || startConv || stopConv) begin
            flagLow_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Serial output
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            outSh_r <= 24'h000000;
        end else if (loadOut) begin
            outSh_r <= outSh_nxt;
        end else if (sclkFall && state_r == ST_READ) begin
            outSh_r <= {outSh_r[22:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            outBit_r <= 1'b1;
        end else if (state_r == ST_READ) begin
            if (sclkFall) begin
                outBit_r <= outSh_r[23];
            end
        end else begin
            outBit_r <= !(pfOn && flagLow_r);
        end
    end

    assign link.serialOut = outBit_r;
    assign link.serialOutEn = !csSync_r[1];
    assign convBusy = convBusy_r;
    assign contMode = contMode_r;
endmodule

// >>> verification/adc_conversion_readout_control_test.sv
// Self-checking bench: APB host sequencer driving the converter end
`timescale 1ns/1ps
`include "adc_link_defines.svh"
module adc_conversion_readout_control_test;
    import adc_link_pkg::*;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, errSeen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdVal;
    logic oscDetect, convBusy, contMode;
    sample_t sampleIn;
    int n_mismatch, n_tests;

    adc_link_if link();
    adc_serial_dev #(.XIN_DIV(4), .CONV_TICKS(200)) i_adc_serial_dev (.core_clk(core_clk),
        .rst(rst), .link(link), .sampleIn(sampleIn), .oscDetect(oscDetect),
        .convBusy(convBusy), .contMode(contMode));
    adc_link_host #(.SCLK_HALF(8)) i_adc_link_host (.core_clk(core_clk), .rst(rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    adc_link_assertions i_adc_link_assertions (.core_clk(core_clk), .rst(rst),
        .csN(link.csN), .sclk(link.sclk), .serialIn(link.serialIn),
        .serialOutEn(link.serialOutEn), .convBusy(convBusy), .contMode(contMode));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rdVal = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    // One link frame, then fetch the captured word
    task automatic frame(input logic [31:0] cmd, input logic [23:0] tx);
        apb(`HOST_TX_OFS, 1'b1, {8'h00, tx});
        apb(`HOST_CMD_OFS, 1'b1, cmd);
        rdVal = 32'h1;
        while (rdVal[0] !== 1'b0) apb(`HOST_STAT_OFS, 1'b0, 32'h0);
        apb(`HOST_RX_OFS, 1'b0, 32'h0);
    endtask

    task automatic poll_done;
        rdVal = 32'h0;
        while (rdVal[`CFG_DONE_BIT] !== 1'b1) frame(32'h191, 24'h0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_poll;
        sampleIn <= 18'sh01234;
        oscDetect <= 1'b1;
        frame(32'hC0, 24'h0);
        frame(32'hC0, 24'h0);
        frame(32'h191, 24'h0);
        check(24'(rdVal[`CFG_DONE_BIT]), 24'h0);
        poll_done;
        frame(32'h191, 24'h0);
        check(24'(rdVal[`CFG_DONE_BIT]), 24'h1);
        frame(32'h196, 24'h0);
        check(rdVal[23:0], 24'h1234F2);
        sampleIn <= 18'sh37FFF;
        oscDetect <= 1'b0;
        frame(32'hC0, 24'h0);
        poll_done;
        frame(32'h193, 24'h0);
        frame(32'h191, 24'h0);
        check(24'(rdVal[`CFG_DONE_BIT]), 24'h0);
        frame(32'h196, 24'h0);
        check(rdVal[23:0], 24'h8000F1);
        frame(32'hA0, 24'h0);
        check(24'({contMode, convBusy}), 24'h0);
        $display("polled conversion test done");
    endtask

    task automatic t_flag;
        frame(32'h181, 24'h001020);
        sampleIn <= 18'sh3FFFB;
        frame(32'hC0, 24'h0);
        frame(32'h300, 24'h0);
        check(rdVal[23:0], 24'h0000F1);
        frame(32'h191, 24'h0);
        check(rdVal[23:0] & 24'hFFFFF7, 24'h001020);
        $display("flagged single test done");
    endtask

    task automatic t_cont;
        frame(32'h181, 24'h000020);
        sampleIn <= 18'sh10000;
        frame(32'hA0, 24'h0);
        check(24'(contMode), 24'h1);
        frame(32'h300, 24'h0);
        check(rdVal[23:0], 24'h7FFFF1);
        sampleIn <= 18'sh00042;
        frame(32'h300, 24'h0);
        check(rdVal[23:0], 24'h0042F0);
        frame(32'h396, 24'h0);
        check(rdVal[23:0], 24'h0042F0);
        check(24'({contMode, convBusy}), 24'h0);
        $display("continuous test done");
    endtask

    task automatic t_unmapped;
        apb(12'h010, 1'b0, 32'h0);
        check({errSeen, rdVal[22:0]}, 24'h800000);
        $display("unmapped access test done");
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sampleIn = 18'sh00000;
        oscDetect = 1'b0;
        n_mismatch = 0;
        n_tests = 0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_poll;
        t_flag;
        t_cont;
        t_unmapped;
        end_of_test;
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        n_mismatch++;
        $display("FAIL at %0t: watchdog expired", $time);
        end_of_test;
    end
endmodule

// >>> verification/adc_link_assertions.sv
// Concurrent checks on the converter link wires and converter status
`timescale 1ns/1ps
module adc_link_assertions (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Link wires
    input wire logic csN,
    input wire logic sclk,
    input wire logic serialIn,
    input wire logic serialOutEn,
    // Converter status
    input wire logic convBusy,
    input wire logic contMode
);
    logic sclkD_r;
    logic [5:0] riseCnt_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Rising sclk edges in the current frame
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        sclkD_r <= sclk;
    end
    always_ff @(posedge core_clk) begin
        if (rst || csN) begin
            riseCnt_r <= 6'h00;
        end else if (sclk && !sclkD_r) begin
            riseCnt_r <= riseCnt_r + 6'h01;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sclk_idle_a: assert property (csN |-> !sclk)
        else $error("sclk moves while deselected");
    cs_edge_a: assert property ($changed(csN) |-> !sclk)
        else $error("chip select changed with sclk high");
    sclk_high_a: assert property ($rose(sclk) |-> sclk [*8])
        else $error("sclk high phase too short");
    sclk_low_a: assert property ($fell(sclk) |-> !sclk [*8])
        else $error("sclk low phase too short");
    sdi_stable_a: assert property (sclk && $past(sclk) |-> $stable(serialIn))
        else $error("serial input moved while sclk high");
    frame_len_a: assert property ($rose(csN) |-> riseCnt_r == 6'h08 || riseCnt_r == 6'h20)
        else $error("frame not 8 or 32 clocks");
    en_off_a: assert property (csN [*5] |-> !serialOutEn)
        else $error("serial output driven while deselected");
    en_rise_a: assert property ($rose(serialOutEn) |-> !csN && !$past(csN))
        else $error("serial output enabled without select");
    cont_busy_a: assert property ($rose(contMode) |-> ##[0:2] convBusy)
        else $error("continuous mode without conversion");
    cont_repeat_a: assert property ($fell(convBusy) && contMode |-> ##[0:8] (convBusy || !contMode))
        else $error("continuous conversions stopped");
    single_once_a: assert property ($fell(convBusy) && !contMode |=> !convBusy)
        else $error("single conversion restarted itself");

    cont_c: cover property ($rose(contMode));
    long_c: cover property ($rose(csN) && riseCnt_r == 6'h20);
    done_c: cover property ($fell(convBusy) && !contMode);
endmodule
